// >>> logic/iec_defs.svh
// timing counts, register offsets and field positions of the external control input
`ifndef IEC_DEFS_SVH
`define IEC_DEFS_SVH

`define IEC_CLK_MHZ 40
`define IEC_TICK_NS 1000
`define IEC_TICK_CYC ((`IEC_TICK_NS * `IEC_CLK_MHZ) / 1000)
`define IEC_TICK_W 6
`define IEC_QUAL_MS 40
`define IEC_QUAL_TICKS ((`IEC_QUAL_MS * 1000000) / `IEC_TICK_NS)
`define IEC_QCNT_W 16

`define IEC_ADDR_W 8
`define IEC_OFF_CTRL 8'h00
`define IEC_OFF_STATUS 8'h04
`define IEC_OFF_INT_STAT 8'h08
`define IEC_OFF_INT_MASK 8'h0c

`define IEC_CTRL_MASTER 0
`define IEC_CTRL_MEAS 1
`define IEC_CTRL_EVT_LO 2
`define IEC_CTRL_EVT_HI 3
`define IEC_CTRL_RST 4'h0

`define IEC_ST_RUN 0
`define IEC_ST_LINE_SS 1
`define IEC_ST_LINE_RST 2
`define IEC_ST_LINE_EVT 3

`define IEC_INT_START 0
`define IEC_INT_STOP 1
`define IEC_INT_CLR 2
`define IEC_INT_EVT 3
`define IEC_INT_W 4
`define IEC_INT_RST 4'h0

`endif

// >>> logic/iec_pkg.sv
// types shared by the external control input block
package iec_pkg;
	typedef enum logic [1:0] {EVT_HOLD, EVT_SAVE, EVT_CAPTURE, EVT_NONE} iec_evt_e;
	typedef enum logic {RUN_STOPPED, RUN_ACTIVE} iec_run_e;
endpackage : iec_pkg

// >>> logic/iec_sync.sv
// three-stage synchroniser with agreement filter for one control pin
`timescale 1ns/10ps
`include "iec_defs.svh"
module iec_sync (
	input wire logic clk, // block clock
	input wire logic rst, // synchronous reset, active high
	input wire logic pin, // asynchronous pin level
	output logic level // filtered level, reset high (line idle)
);
	import iec_pkg::*;
	logic ff1_q;
	logic ff2_q;
	logic ff3_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			ff1_q <= 1'b1;
			ff2_q <= 1'b1;
			ff3_q <= 1'b1;
		end else begin
			ff1_q <= pin;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			level <= 1'b1;
		end else if (ff2_q == ff3_q) begin
			level <= ff3_q; // RQ13
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_sync_agree: assert property ($changed(level) |-> $past(ff2_q) == $past(ff3_q)) // RQ13
		else $error("level changed without stage agreement");
endmodule : iec_sync

// >>> logic/iec_lowq.sv
// low-pulse qualifier: one pulse per low period that lasts the qualifying tick count
`timescale 1ns/10ps
`include "iec_defs.svh"
module iec_lowq #(
	parameter int QUAL_TICKS = `IEC_QUAL_TICKS // ticks the line must stay low
) (
	input wire logic clk, // block clock
	input wire logic rst, // synchronous reset, active high
	input wire logic tick, // periodic sample strobe
	input wire logic level, // synchronised line level
	output logic hit // one-cycle pulse when qualified
);
	import iec_pkg::*;
	logic [`IEC_QCNT_W-1:0] cnt_q;
	logic armed_q;
	logic fire;

	assign fire = tick && !level && armed_q && (cnt_q == QUAL_TICKS[`IEC_QCNT_W-1:0] - 1'b1);

	// counter restarts whenever the line is seen high
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (tick) begin
			if (level || !armed_q) begin
				cnt_q <= '0; // RQ13
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// one acceptance per low assertion; rearm only on a high sample
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_q <= 1'b1;
		end else if (fire) begin
			armed_q <= 1'b0; // RQ14
		end else if (tick && level) begin
			armed_q <= 1'b1; // RQ14
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hit <= 1'b0;
		end else begin
			hit <= fire;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_restart_high: assert property (tick && level |=> cnt_q == '0) // RQ13
		else $error("qualifier count not restarted by high line");
	a_single_shot: assert property (hit |-> !armed_q && !$past(level)) // RQ14
		else $error("qualified pulse while line high or still armed");
	a_no_rearm_low: assert property (!armed_q && !level |=> !hit) // RQ14
		else $error("second pulse in one low period");
endmodule : iec_lowq

// >>> logic/iec_ctl.sv
// external integration control: start/stop, accumulator clear and event lines with APB registers
// How it works
// RQ1 - a reset line held low for at least 40 ms clears the integration accumulator.
// RQ2 - an accumulator clear is honoured only while integration is stopped.
// RQ3 - a high-to-low change on the start/stop line starts integration.
// RQ4 - a low-to-high change on the start/stop line stops integration.
// RQ5 - an event line held low for at least 40 ms fires the configured event action.
// RQ6 - an event request while integration runs is ignored.
// RQ7 - the controller waits 250 ms (1 s with auto-save) after a stop before reset or event; the controller model here waits GAP_CYC = 200 cycles.
// RQ8 - the lines are acted on only when the unit is configured as master.
// RQ9 - the lines are acted on only while the measurement view is active.
// RQ10 - external start/stop and reset share one command path with the panel keys.
// RQ11 - the controller drives bounce-free levels on every line.
// RQ12 - the event action is data hold, manual save or screen capture.
// RQ13 - each line is synchronised, sampled on a periodic tick, and low-qualified by a restarting counter; the start/stop line is not low-qualified here.
// RQ14 - a qualified reset or event is taken once per low; the line must go high again first.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "iec_defs.svh"
module iec_ctl #(
	parameter int QUAL_TICKS = `IEC_QUAL_TICKS // low-qualify time in sample ticks
) (
	input wire logic CLK, // 40 MHz block clock
	input wire logic SYS_RST, // synchronous reset, active high
	input wire logic PIN_SS_N, // start/stop line, low = run
	input wire logic PIN_CLR_N, // accumulator reset line, active low
	input wire logic PIN_EVT_N, // event line, active low
	input wire logic KEY_START_STOP, // panel start/stop key pulse
	input wire logic KEY_DATA_RESET, // panel data reset key pulse
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [`IEC_ADDR_W-1:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	output logic CMD_START, // start integration pulse
	output logic CMD_STOP, // stop integration pulse
	output logic CMD_ACC_CLR, // clear accumulator pulse
	output logic CMD_HOLD, // data hold event pulse
	output logic CMD_SAVE, // manual save event pulse
	output logic CMD_CAPTURE, // screen capture event pulse
	output iec_pkg::iec_run_e RUN_STATE, // integration state
	output logic IRQ // level interrupt
);
	import iec_pkg::*;

	logic ss_lvl;
	logic clr_lvl;
	logic evt_lvl;
	logic [`IEC_TICK_W-1:0] tick_cnt_q;
	logic tick_q;
	logic ss_samp_q;
	logic clr_hit;
	logic evt_hit;
	logic [3:0] ctrl_q;
	logic [`IEC_INT_W-1:0] int_stat_q;
	logic [`IEC_INT_W-1:0] int_mask_q;
	logic [`IEC_INT_W-1:0] int_set;
	iec_run_e run_q;
	logic running;
	logic gate;
	logic ext_fall;
	logic ext_rise;
	logic start_req;
	logic stop_req;
	logic clr_req;
	logic evt_go;
	iec_evt_e evt_sel;
	logic wr_en;
	logic rd_setup;
	logic mapped;

	// true when an address hits one of the four words
	function automatic logic addr_hit(input logic [`IEC_ADDR_W-1:0] a);
		addr_hit = (a == `IEC_OFF_CTRL) || (a == `IEC_OFF_STATUS) ||
			(a == `IEC_OFF_INT_STAT) || (a == `IEC_OFF_INT_MASK);
	endfunction : addr_hit

	// pin synchronisers
	iec_sync u_sync_ss (.clk(CLK), .rst(SYS_RST), .pin(PIN_SS_N), .level(ss_lvl));
	iec_sync u_sync_clr (.clk(CLK), .rst(SYS_RST), .pin(PIN_CLR_N), .level(clr_lvl));
	iec_sync u_sync_evt (.clk(CLK), .rst(SYS_RST), .pin(PIN_EVT_N), .level(evt_lvl));

	// periodic sample tick; slow sampling also rides over short glitches
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == `IEC_TICK_W'(`IEC_TICK_CYC - 1)) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1; // RQ13
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// start/stop line sampled on the tick for edge detection
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ss_samp_q <= 1'b1;
		end else if (tick_q) begin
			ss_samp_q <= ss_lvl; // RQ13
		end
	end

	// low qualifiers for the reset and event lines
	iec_lowq #(.QUAL_TICKS(QUAL_TICKS)) u_q_clr (.clk(CLK), .rst(SYS_RST), .tick(tick_q),
		.level(clr_lvl), .hit(clr_hit));
	iec_lowq #(.QUAL_TICKS(QUAL_TICKS)) u_q_evt (.clk(CLK), .rst(SYS_RST), .tick(tick_q),
		.level(evt_lvl), .hit(evt_hit));

	// external requests need master role and measurement view
	assign gate = ctrl_q[`IEC_CTRL_MASTER] && ctrl_q[`IEC_CTRL_MEAS]; // RQ8 RQ9
	assign running = (run_q == RUN_ACTIVE);
	assign ext_fall = tick_q && ss_samp_q && !ss_lvl;
	assign ext_rise = tick_q && !ss_samp_q && ss_lvl;
	assign evt_sel = iec_evt_e'(ctrl_q[`IEC_CTRL_EVT_HI:`IEC_CTRL_EVT_LO]);

	// keys and pins merge into one command path
	assign start_req = !running && ((ext_fall && gate) || KEY_START_STOP); // RQ3 RQ10
	assign stop_req = running && ((ext_rise && gate) || KEY_START_STOP); // RQ4 RQ10
	assign clr_req = !running && ((clr_hit && gate) || KEY_DATA_RESET); // RQ1 RQ2 RQ10
	assign evt_go = !running && evt_hit && gate; // RQ5 RQ6

	// integration state
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			run_q <= RUN_STOPPED;
		end else begin
			case (run_q)
				RUN_STOPPED: begin
					if (start_req) begin
						run_q <= RUN_ACTIVE; // RQ3
					end
				end
				RUN_ACTIVE: begin
					if (stop_req) begin
						run_q <= RUN_STOPPED; // RQ4
					end
				end
				default: begin
					run_q <= RUN_STOPPED;
				end
			endcase
		end
	end
	assign RUN_STATE = run_q;

	// command pulses, all registered
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			CMD_START <= 1'b0;
			CMD_STOP <= 1'b0;
			CMD_ACC_CLR <= 1'b0;
		end else begin
			CMD_START <= start_req; // RQ3
			CMD_STOP <= stop_req; // RQ4
			CMD_ACC_CLR <= clr_req; // RQ1
		end
	end

	// event action by configured selection; none selected means nothing fires
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			CMD_HOLD <= 1'b0;
			CMD_SAVE <= 1'b0;
			CMD_CAPTURE <= 1'b0;
		end else begin
			CMD_HOLD <= evt_go && (evt_sel == EVT_HOLD); // RQ5 RQ12
			CMD_SAVE <= evt_go && (evt_sel == EVT_SAVE); // RQ12
			CMD_CAPTURE <= evt_go && (evt_sel == EVT_CAPTURE); // RQ12
		end
	end

	// apb decode: zero wait states, read data latched in the setup cycle
	assign mapped = addr_hit(PADDR);
	assign wr_en = PSEL && PENABLE && PWRITE && mapped;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// control register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_q <= `IEC_CTRL_RST;
		end else if (wr_en && PADDR == `IEC_OFF_CTRL) begin
			ctrl_q <= PWDATA[3:0];
		end
	end

	// mask register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			int_mask_q <= `IEC_INT_RST;
		end else if (wr_en && PADDR == `IEC_OFF_INT_MASK) begin
			int_mask_q <= PWDATA[`IEC_INT_W-1:0];
		end
	end

	// sticky status; a new event wins over a write-one clear in the same cycle
	assign int_set = {evt_go, clr_req, stop_req, start_req};
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			int_stat_q <= `IEC_INT_RST;
		end else if (wr_en && PADDR == `IEC_OFF_INT_STAT) begin
			int_stat_q <= (int_stat_q & ~PWDATA[`IEC_INT_W-1:0]) | int_set;
		end else begin
			int_stat_q <= int_stat_q | int_set;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(int_stat_q & int_mask_q);
		end
	end

	// read data mux
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PRDATA <= '0;
		end else if (rd_setup) begin
			case (PADDR)
				`IEC_OFF_CTRL: PRDATA <= {28'h0000000, ctrl_q};
				`IEC_OFF_STATUS: PRDATA <= {28'h0000000, evt_lvl, clr_lvl, ss_lvl, running};
				`IEC_OFF_INT_STAT: PRDATA <= {28'h0000000, int_stat_q};
				`IEC_OFF_INT_MASK: PRDATA <= {28'h0000000, int_mask_q};
				default: PRDATA <= '0;
			endcase
		end
	end

	// every check runs on the block clock and stays quiet while reset is high
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_line_fall;
		tick_q && ss_samp_q && !ss_lvl;
	endsequence
	sequence s_started;
		CMD_START && running ##1 !CMD_START;
	endsequence

	a_start_fall: assert property (s_line_fall ##0 (gate && !running) |=> s_started) // RQ3
		else $error("falling start/stop line did not start integration");
	a_stop_rise: assert property (ext_rise && gate && running |=> CMD_STOP && !running) // RQ4
		else $error("rising start/stop line did not stop integration");
	a_clr_stopped: assert property (CMD_ACC_CLR |-> !$past(running)) // RQ2
		else $error("accumulator clear while integration ran");
	a_clr_qualified: assert property (clr_hit && gate && !running |=> CMD_ACC_CLR) // RQ1
		else $error("qualified reset line did not clear accumulator");
	a_gate_master: assert property (!ctrl_q[`IEC_CTRL_MASTER] && !KEY_START_STOP |=> !CMD_START && !CMD_STOP) // RQ8
		else $error("start/stop acted on without master role");
	a_gate_view: assert property (!ctrl_q[`IEC_CTRL_MEAS] && !KEY_DATA_RESET |=> !CMD_ACC_CLR) // RQ9
		else $error("reset acted on outside measurement view");
	a_evt_running: assert property (running |=> !CMD_HOLD && !CMD_SAVE && !CMD_CAPTURE) // RQ6
		else $error("event fired while integration ran");
	a_evt_select: assert property (evt_go && evt_sel == EVT_SAVE |=> CMD_SAVE && !CMD_HOLD ##1 !CMD_SAVE) // RQ5 RQ12
		else $error("event action does not match selection");
	a_key_merge: assert property (KEY_DATA_RESET && !running |=> CMD_ACC_CLR) // RQ10
		else $error("panel reset key not on shared path");
	a_irq_level: assert property (|(int_stat_q & int_mask_q) |=> IRQ)
		else $error("unmasked status did not raise interrupt");

	// event actions are exclusive; each selection drives only its own pulse
	a_evt_hold: assert property (evt_go && evt_sel == EVT_HOLD |=> CMD_HOLD && !CMD_SAVE && !CMD_CAPTURE) // RQ5 RQ12
		else $error("hold selection did not fire hold alone");
	a_evt_capture: assert property (evt_go && evt_sel == EVT_CAPTURE |=> CMD_CAPTURE && !CMD_HOLD && !CMD_SAVE) // RQ12
		else $error("capture selection did not fire capture alone");
	a_evt_none: assert property (evt_go && evt_sel == EVT_NONE |=> !CMD_HOLD && !CMD_SAVE && !CMD_CAPTURE) // RQ12
		else $error("event fired with no action selected");

	// a closed gate must block events too, not only start, stop and clear
	a_evt_gate: assert property (!gate |=> !CMD_HOLD && !CMD_SAVE && !CMD_CAPTURE) // RQ8 RQ9
		else $error("event fired without master role and measurement view");

	// the panel key stops integration through the same path as the line
	sequence s_key_stop;
		KEY_START_STOP && running;
	endsequence
	a_key_stop: assert property (s_key_stop |=> CMD_STOP && !running) // RQ10
		else $error("panel start/stop key did not stop integration");

	// while integration runs no clear may follow, whatever the source
	a_clr_running: assert property (running |=> !CMD_ACC_CLR) // RQ2
		else $error("accumulator clear issued while integration ran");

	// the sample strobe is a single-cycle pulse
	a_tick_pulse: assert property (tick_q |=> !tick_q) // RQ13
		else $error("sample tick lasted more than one cycle");

	// status bits are sticky: a set always lands, even against a clear
	a_stat_set: assert property (|int_set |=> (int_stat_q & $past(int_set)) == $past(int_set))
		else $error("status bit lost its set event");

	// a start leaves the unit running, so a second start pulse cannot follow
	a_start_once: assert property (CMD_START |=> !CMD_START) // RQ3
		else $error("start pulse lasted more than one cycle");
endmodule : iec_ctl

// >>> dv/iec_ctrl_model.sv
// external controller model driving the start/stop, clear and event lines
`timescale 1ns/10ps
module iec_ctrl_model #(
	parameter int GAP_CYC = 200 // settle cycles after a stop, shortened
) (
	input wire logic clk, // block clock
	output logic ss_n, // start/stop line, low = run
	output logic clr_n, // accumulator reset line
	output logic evt_n // event line
);
	int cyc = 0;
	int stop_cyc = 0;
	// lines idle high as the pull-up leaves them; one clean change, no chatter
	initial begin
		ss_n = 1'b1;
		clr_n = 1'b1;
		evt_n = 1'b1;
	end
	// free cycle count for the settle time
	always @(posedge clk) cyc <= cyc + 1;
	// level change of the start/stop line, just after an edge
	task set_ss(input logic v);
		ss_n <= v;
		if (v) stop_cyc = cyc;
		@(posedge clk);
	endtask : set_ss
	// low pulse on clear (0) or event (1); waits out the settle time when stopped
	task low(input int line, input int n);
		if (ss_n) while (cyc - stop_cyc < GAP_CYC) @(posedge clk);
		if (line == 0) clr_n <= 1'b0;
		else evt_n <= 1'b0;
		repeat (n) @(posedge clk);
		clr_n <= 1'b1;
		evt_n <= 1'b1;
		@(posedge clk);
	endtask : low
endmodule : iec_ctrl_model

// >>> dv/tb.sv
// self-checking bench for the external control input block
`timescale 1ns/10ps
module tb;
	import iec_pkg::*;
	localparam int QT = 4;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic KEY_START_STOP = 1'b0;
	logic KEY_DATA_RESET = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, CMD_START, CMD_STOP, CMD_ACC_CLR, CMD_HOLD, CMD_SAVE, CMD_CAPTURE, IRQ;
	logic ss_n, clr_n, evt_n, e, lng;
	iec_run_e RUN_STATE;
	logic [31:0] v;
	logic [5:0] cmds;
	int cnt [6];
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 32'h75da;
	int n;
	// 40 MHz clock
	always #12.5 CLK = ~CLK;
	iec_ctl #(.QUAL_TICKS(QT)) u_iec_ctl (.CLK(CLK), .SYS_RST(SYS_RST), .PIN_SS_N(ss_n), .PIN_CLR_N(clr_n),
		.PIN_EVT_N(evt_n), .KEY_START_STOP(KEY_START_STOP), .KEY_DATA_RESET(KEY_DATA_RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CMD_START(CMD_START), .CMD_STOP(CMD_STOP), .CMD_ACC_CLR(CMD_ACC_CLR),
		.CMD_HOLD(CMD_HOLD), .CMD_SAVE(CMD_SAVE), .CMD_CAPTURE(CMD_CAPTURE), .RUN_STATE(RUN_STATE), .IRQ(IRQ));
	iec_ctrl_model u_iec_ctrl_model (.clk(CLK), .ss_n(ss_n), .clr_n(clr_n), .evt_n(evt_n));
	// count command pulses, one cycle each
	assign cmds = {CMD_CAPTURE, CMD_SAVE, CMD_HOLD, CMD_ACC_CLR, CMD_STOP, CMD_START};
	always @(posedge CLK) for (int i = 0; i < 6; i++) if (cmds[i] === 1'b1) cnt[i]++;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// each command seen exactly as often as its bit says, then restart the counts
	task chk_cnt(input logic [5:0] exp);
		for (int i = 0; i < 6; i++) chk($sformatf("cmd%0d pulses", i), cnt[i], {31'h0, exp[i]});
		foreach (cnt[i]) cnt[i] = 0;
	endtask : chk_cnt
	// one apb transfer, entered just after a rising edge; waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic er);
		int k;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (PREADY !== 1'b1);
		r = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		chk("pready wait", k, 32'h1);
		// one idle edge so the next setup never reassigns psel in this step
		@(posedge CLK);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, v, e);
	endtask : wr
	task automatic idle(input int c);
		repeat (c) @(posedge CLK);
	endtask : idle
	// panel key pulse: 0 start/stop, 1 data reset
	task key(input int k);
		if (k == 0) KEY_START_STOP <= 1'b1;
		else KEY_DATA_RESET <= 1'b1;
		@(posedge CLK);
		KEY_START_STOP <= 1'b0;
		KEY_DATA_RESET <= 1'b0;
		idle(5);
	endtask : key
	task end_sim;
		if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	// hang guard, well beyond the expected run
	initial begin
		idle(60000);
		n_mismatch++;
		end_sim;
	end
	// main sequence
	initial begin
		foreach (cnt[i]) cnt[i] = 0;
		idle(6);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		apb(1'b0, 8'h00, 32'h0, v, e); chk("ctrl reset", v, 32'h0);
		apb(1'b0, 8'h04, 32'h0, v, e); chk("status idle", v, 32'he);
		apb(1'b0, 8'h10, 32'h0, v, e); chk("unmapped err", e, 32'h1);
		chk("unmapped data", v, 32'h0);
		// no master, no view, or only one of them: lines do nothing
		for (int c = 0; c < 3; c++) begin
			wr(8'h00, c);
			u_iec_ctrl_model.set_ss(1'b0);
			idle(100);
			u_iec_ctrl_model.set_ss(1'b1);
			u_iec_ctrl_model.low(0, 300);
			idle(100);
			chk_cnt(6'h00);
		end
		wr(8'h00, 32'h3);
		wr(8'h0c, 32'hf);
		u_iec_ctrl_model.set_ss(1'b0);
		idle(100);
		chk_cnt(6'h01);
		chk("run", RUN_STATE, RUN_ACTIVE);
		chk("irq on", IRQ, 32'h1);
		// clear and event while running are lost
		u_iec_ctrl_model.low(0, 300);
		u_iec_ctrl_model.low(1, 300);
		idle(60);
		chk_cnt(6'h00);
		u_iec_ctrl_model.set_ss(1'b1);
		idle(100);
		chk_cnt(6'h02);
		apb(1'b0, 8'h08, 32'h0, v, e); chk("int stat", v, 32'h3);
		wr(8'h08, 32'h3);
		idle(3);
		chk("irq off", IRQ, 32'h0);
		// random short or long clear lows; short ones never qualify
		for (int i = 0; i < 4; i++) begin
			lng = $random(seed);
			n = lng ? 300 + {$random(seed)} % 200 : 60 + {$random(seed)} % 40;
			u_iec_ctrl_model.low(0, n);
			idle(60);
			chk_cnt(lng ? 6'h04 : 6'h00);
		end
		// every event action, the last one does nothing
		for (int s = 0; s < 4; s++) begin
			wr(8'h00, 32'h3 | (s << 2));
			u_iec_ctrl_model.low(1, 300);
			idle(60);
			chk_cnt(s == 3 ? 6'h00 : 6'h08 << s);
		end
		wr(8'h0c, 32'h0);
		idle(3);
		chk("irq masked", IRQ, 32'h0);
		apb(1'b0, 8'h08, 32'h0, v, e); chk("evt stat", v[3], 32'h1);
		wr(8'h08, 32'hf);
		apb(1'b0, 8'h08, 32'h0, v, e); chk("stat cleared", v, 32'h0);
		// panel keys share the command path
		key(0);
		key(1);
		chk_cnt(6'h01);
		key(0);
		key(1);
		chk_cnt(6'h06);
		// reset in mid-run returns to stopped
		key(0);
		SYS_RST <= 1'b1;
		idle(2);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		chk("run after reset", RUN_STATE, RUN_STOPPED);
		chk_cnt(6'h01);
		chk("irq after reset", IRQ, 32'h0);
		apb(1'b0, 8'h00, 32'h0, v, e);
		chk("ctrl after reset", v, 32'h0);
		end_sim;
	end
endmodule : tb
